/* File: spg_bod_if.sv */
`timescale 1ns/100ps
interface spg_bod_if;
    logic arm;
    logic set_req;
    logic active;
    logic [2:0] age;
    modport ctrl (output arm, output set_req, input active, input age);
    modport seq (input arm, input set_req, output active, output age);
endinterface : spg_bod_if

/* File: spg_bod_seq.sv */
`timescale 1ns/100ps
module spg_bod_seq
    import spg_pkg::*;
(
    // clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // control side
    spg_bod_if.seq bod
);
    localparam int CW = 3;
    initial begin
        if (UNLOCK_WINDOW_CYC >= (1 << CW) || BROWNOUT_ACTIVE_CYC >= (1 << CW))
            $error("spg_bod_seq: counter too narrow");
    end
    logic [CW-1:0] win_q;
    logic [CW-1:0] age_q;
    logic pend_q;
    logic active_q;

    // ******************************
    // unlock window
    // ******************************
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            win_q <= '0;
        end else if (bod.arm) begin
            win_q <= CW'(UNLOCK_WINDOW_CYC);
        end else if (win_q != '0) begin
            win_q <= win_q - 1'b1;
        end
    end

    // ******************************
    // set delay and auto clear
    // ******************************
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            pend_q <= 1'b0;
            active_q <= 1'b0;
            age_q <= '0;
        end else if (bod.set_req && win_q != '0 && !bod.arm) begin
            // accepted only inside the window
            pend_q <= 1'b1;
            active_q <= 1'b0;
            age_q <= '0;
        end else if (pend_q || active_q) begin
            age_q <= age_q + 1'b1;
            if (pend_q && age_q == CW'(BROWNOUT_ACTIVE_CYC - 1)) begin
                pend_q <= 1'b0;
                active_q <= 1'b1;
                age_q <= '0;
            end else if (active_q && age_q == CW'(BROWNOUT_ACTIVE_CYC - 1)) begin
                active_q <= 1'b0;
                age_q <= '0;
            end
        end
    end

    assign bod.active = active_q;
    assign bod.age = age_q;
endmodule : spg_bod_seq

/* File: spg_pkg.sv */
package spg_pkg;
    // apb byte addresses
    localparam logic [7:0] ADDR_POWER_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_POWER_GATE = 8'h04;
    localparam logic [7:0] ADDR_SYS_CONFIG = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    // mcu_power_control fields
    localparam int BIT_BROWNOUT_OFF = 7;
    localparam int BIT_PULLUP_OFF = 6;
    localparam int BIT_SLEEP_PERMIT = 5;
    localparam int BIT_KIND_HIGH = 4;
    localparam int BIT_KIND_LOW = 3;
    localparam int BIT_BROWNOUT_UNLOCK = 2;
    localparam int BIT_SENSE_HIGH = 1;
    localparam int BIT_SENSE_LOW = 0;
    // peripheral_power_gate fields
    localparam int BIT_GATE_WIDE_TIMER = 3;
    localparam int BIT_GATE_NARROW_TIMER = 2;
    localparam int BIT_GATE_SERIAL = 1;
    localparam int BIT_GATE_CONVERTER = 0;
    localparam logic [7:0] GATE_WRITE_MASK = 8'h0f;
    // sys_config fields
    localparam int BIT_CFG_BROWNOUT_FUSE = 0;
    localparam int BIT_CFG_CMP_ENABLE = 1;
    localparam int BIT_CFG_CMP_REF = 2;
    localparam int BIT_CFG_CMP_MUX = 3;
    localparam int BIT_CFG_CONV_ENABLE = 4;
    localparam int BIT_CFG_WATCHDOG = 5;
    localparam int BIT_CFG_XTAL = 6;
    // reset values
    localparam logic [7:0] RST_POWER_CONTROL = 8'h00;
    localparam logic [7:0] RST_POWER_GATE = 8'h00;
    localparam logic [7:0] RST_SYS_CONFIG = 8'h00;
    // timing in clock cycles
    localparam int UNLOCK_WINDOW_CYC = 4;
    localparam int BROWNOUT_ACTIVE_CYC = 3;
    localparam int WAKE_HALT_CYC = 4;
    localparam logic [15:0] STARTUP_CYC_DEFAULT = 16'h0010;
    typedef enum logic [1:0] {
        SPG_IDLE_MODE,
        SPG_NOISE_REDUCTION,
        SPG_POWER_DOWN,
        SPG_STANDBY
    } spg_kind_t;
    typedef enum {
        SPG_RUN,
        SPG_ASLEEP,
        SPG_STARTUP,
        SPG_HALT
    } spg_state_t;
endpackage : spg_pkg

/* File: spg_top.sv */
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
// Overview of operation
// - off-in-sleep bit becomes active three cycles after its accepted set
// - detector off only if sleep executes while off-in-sleep bit is active
// - hardware clears off-in-sleep bit three cycles after it became active
// - unlock bit at position 2 permits setting the off-in-sleep bit
// - sleep instruction sleeps only when sleep permit bit 5 is one
// - bits 4:3 pick idle, noise reduction, power-down or standby
// - gate register bits 7 to 4 read zero
// - bit 3 freezes wide timer, clearing resumes where it stopped
// - bit 2 freezes narrow timer, clearing resumes from frozen state
// - bit 1 stops serial unit clock; software reinitialises afterwards
// - converter gated means comparator cannot use converter input mux
// - io and converter clocks both stopped disables input buffers except wake pins
// - comparator forced off in power-down and standby unless it is on the internal reference
// - comparator on internal reference keeps reference on in all sleep modes
// - reference powered only when detector, comparator or converter needs it
// - fuse-enabled detector stays on in sleep unless disable sequence used
// - enabled watchdog keeps running in every sleep mode
// - wake by interrupt halts four cycles after start-up, then continues
module spg_top
    import spg_pkg::*;
#(
    parameter logic [15:0] STARTUP_CYC = STARTUP_CYC_DEFAULT
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // cpu side
    input wire logic SLEEP_INSTR,
    input wire logic WAKE_IRQ,
    input wire logic [11:0] WAKE_PIN_MASK,
    output logic CPU_CLK_EN,
    output logic IO_CLK_EN,
    output logic CONV_CLK_EN,
    output logic OSC_EN,
    // peripheral controls
    output logic WIDE_TIMER_CLK_EN,
    output logic NARROW_TIMER_CLK_EN,
    output logic SERIAL_CLK_EN,
    output logic CONV_POWER_EN,
    output logic CMP_MUX_EN,
    output logic CMP_POWER_EN,
    output logic REF_EN,
    output logic BROWNOUT_EN,
    output logic WATCHDOG_RUN,
    output logic [11:0] INPUT_BUF_EN
);
    initial begin
        if (STARTUP_CYC == 16'h0000)
            $error("spg_top: STARTUP_CYC must be at least one");
    end

    // ******************************
    // apb decode
    // ******************************
    logic [7:0] ctrl_q;
    logic [7:0] gate_q;
    logic [7:0] cfg_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    spg_state_t state_q;
    logic [15:0] cnt_q;
    logic bod_off_q;
    spg_kind_t kind_q;
    spg_bod_if bod_bus ();

    logic acc;
    logic wr;
    logic known;
    assign acc = PSEL && PENABLE && !pready_q;
    assign wr = acc && PWRITE;
    assign known = PADDR == ADDR_POWER_CONTROL || PADDR == ADDR_POWER_GATE
        || PADDR == ADDR_SYS_CONFIG || PADDR == ADDR_STATUS;

    logic wr_ctrl;
    assign wr_ctrl = wr && PADDR == ADDR_POWER_CONTROL;
    assign bod_bus.arm = wr_ctrl && PWDATA[BIT_BROWNOUT_OFF] && PWDATA[BIT_BROWNOUT_UNLOCK];
    assign bod_bus.set_req = wr_ctrl && PWDATA[BIT_BROWNOUT_OFF]
        && !PWDATA[BIT_BROWNOUT_UNLOCK];

    spg_bod_seq u_bod (
        .MCLK(MCLK),
        .RESETN(RESETN),
        .bod(bod_bus)
    );

    // ******************************
    // registers
    // ******************************
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            ctrl_q <= RST_POWER_CONTROL;
        end else if (wr_ctrl) begin
            // off-in-sleep bit lives in the sequencer, not here
            ctrl_q <= PWDATA[7:0] & ~(8'h01 << BIT_BROWNOUT_OFF);
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            gate_q <= RST_POWER_GATE;
        end else if (wr && PADDR == ADDR_POWER_GATE) begin
            gate_q <= PWDATA[7:0] & GATE_WRITE_MASK;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            cfg_q <= RST_SYS_CONFIG;
        end else if (wr && PADDR == ADDR_SYS_CONFIG) begin
            cfg_q <= PWDATA[7:0];
        end
    end

    logic [7:0] ctrl_view;
    always_comb begin
        ctrl_view = ctrl_q;
        ctrl_view[BIT_BROWNOUT_OFF] = bod_bus.active;
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= acc;
            pslverr_q <= acc && !known;
            if (acc && !PWRITE) begin
                case (PADDR)
                    ADDR_POWER_CONTROL: prdata_q <= {24'h000000, ctrl_view};
                    ADDR_POWER_GATE: prdata_q <= {24'h000000, gate_q};
                    ADDR_SYS_CONFIG: prdata_q <= {24'h000000, cfg_q};
                    ADDR_STATUS: prdata_q <= {24'h000000, 3'h0, bod_off_q,
                        state_q == SPG_ASLEEP, state_q != SPG_RUN, kind_q};
                    default: prdata_q <= 32'h0000_0000;
                endcase
            end else begin
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    // ******************************
    // sleep sequencer
    // ******************************
    spg_kind_t sel_kind;
    assign sel_kind = spg_kind_t'({ctrl_q[BIT_KIND_HIGH], ctrl_q[BIT_KIND_LOW]});

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            state_q <= SPG_RUN;
            cnt_q <= 16'h0000;
            kind_q <= SPG_IDLE_MODE;
            bod_off_q <= 1'b0;
        end else begin
            case (state_q)
                SPG_RUN: begin
                    if (SLEEP_INSTR && ctrl_q[BIT_SLEEP_PERMIT]) begin
                        state_q <= SPG_ASLEEP;
                        kind_q <= sel_kind;
                        // only deep modes honour the off bit
                        bod_off_q <= bod_bus.active
                            && (sel_kind == SPG_POWER_DOWN || sel_kind == SPG_STANDBY);
                    end
                end
                SPG_ASLEEP: begin
                    if (WAKE_IRQ) begin
                        state_q <= SPG_STARTUP;
                        cnt_q <= STARTUP_CYC;
                        bod_off_q <= 1'b0;
                    end
                end
                SPG_STARTUP: begin
                    if (cnt_q == 16'h0001) begin
                        state_q <= SPG_HALT;
                        cnt_q <= 16'(WAKE_HALT_CYC);
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                SPG_HALT: begin
                    if (cnt_q == 16'h0001) begin
                        state_q <= SPG_RUN;
                        cnt_q <= 16'h0000;
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                default: state_q <= SPG_RUN;
            endcase
        end
    end

    // ******************************
    // clock and power outputs
    // ******************************
    logic asleep;
    logic deep;
    logic io_on;
    logic conv_on;
    logic cmp_on;
    logic conv_pwr;
    assign asleep = state_q != SPG_RUN;
    assign deep = asleep && (kind_q == SPG_POWER_DOWN || kind_q == SPG_STANDBY);
    assign io_on = !asleep || kind_q == SPG_IDLE_MODE;
    assign conv_on = !asleep || kind_q == SPG_IDLE_MODE || kind_q == SPG_NOISE_REDUCTION;
    assign conv_pwr = cfg_q[BIT_CFG_CONV_ENABLE] && !gate_q[BIT_GATE_CONVERTER];
    // reference-fed comparator is kept alive in sleep
    assign cmp_on = cfg_q[BIT_CFG_CMP_ENABLE] && (!deep || cfg_q[BIT_CFG_CMP_REF]);

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            CPU_CLK_EN <= 1'b1;
            IO_CLK_EN <= 1'b1;
            CONV_CLK_EN <= 1'b1;
            OSC_EN <= 1'b1;
            WIDE_TIMER_CLK_EN <= 1'b1;
            NARROW_TIMER_CLK_EN <= 1'b1;
            SERIAL_CLK_EN <= 1'b1;
            CONV_POWER_EN <= 1'b0;
            CMP_MUX_EN <= 1'b0;
            CMP_POWER_EN <= 1'b0;
            REF_EN <= 1'b0;
            BROWNOUT_EN <= 1'b0;
            WATCHDOG_RUN <= 1'b0;
            INPUT_BUF_EN <= 12'hfff;
        end else begin
            CPU_CLK_EN <= !asleep;
            IO_CLK_EN <= io_on;
            CONV_CLK_EN <= conv_on;
            OSC_EN <= !asleep || kind_q != SPG_POWER_DOWN
                || (kind_q == SPG_STANDBY && cfg_q[BIT_CFG_XTAL]);
            WIDE_TIMER_CLK_EN <= io_on && !gate_q[BIT_GATE_WIDE_TIMER];
            NARROW_TIMER_CLK_EN <= io_on && !gate_q[BIT_GATE_NARROW_TIMER];
            SERIAL_CLK_EN <= io_on && !gate_q[BIT_GATE_SERIAL];
            CONV_POWER_EN <= conv_pwr;
            CMP_MUX_EN <= cfg_q[BIT_CFG_CMP_MUX] && !gate_q[BIT_GATE_CONVERTER];
            CMP_POWER_EN <= cmp_on;
            REF_EN <= (cfg_q[BIT_CFG_BROWNOUT_FUSE] && !bod_off_q)
                || (cmp_on && cfg_q[BIT_CFG_CMP_REF]) || conv_pwr;
            BROWNOUT_EN <= cfg_q[BIT_CFG_BROWNOUT_FUSE] && !bod_off_q;
            WATCHDOG_RUN <= cfg_q[BIT_CFG_WATCHDOG];
            INPUT_BUF_EN <= (io_on || conv_on) ? 12'hfff : WAKE_PIN_MASK;
        end
    end

    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
endmodule : spg_top

/* File: spg_top_props.sv */
`timescale 1ns/100ps
// ****************************************
// power control port checker
// ****************************************
module spg_top_props
    import spg_pkg::*;
#(
    parameter logic [15:0] STARTUP_CYC = STARTUP_CYC_DEFAULT
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // apb
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    // cpu side
    input wire logic SLEEP_INSTR,
    input wire logic WAKE_IRQ,
    input wire logic [11:0] WAKE_PIN_MASK,
    input wire logic CPU_CLK_EN,
    input wire logic IO_CLK_EN,
    input wire logic CONV_CLK_EN,
    // peripheral controls
    input wire logic WIDE_TIMER_CLK_EN,
    input wire logic NARROW_TIMER_CLK_EN,
    input wire logic SERIAL_CLK_EN,
    input wire logic CONV_POWER_EN,
    input wire logic CMP_POWER_EN,
    input wire logic REF_EN,
    input wire logic [11:0] INPUT_BUF_EN
);
    localparam int WAKE_HI = int'(STARTUP_CYC) + 6;
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RESETN);
    // cpu stays stopped for at least four cycles, the length of the halt alone
    sequence held_asleep;
        !CPU_CLK_EN [*4];
    endsequence
    sleep_entry_a: assert property ($fell(CPU_CLK_EN) |-> $past(SLEEP_INSTR, 2))
        else $error("cpu clock stopped without sleep instruction");
    wake_time_a: assert property ($rose(WAKE_IRQ) && !CPU_CLK_EN |->
        held_asleep ##[1:WAKE_HI] CPU_CLK_EN) else $error("wake timing wrong");
    buf_deep_a: assert property (!IO_CLK_EN && !CONV_CLK_EN |->
        INPUT_BUF_EN == WAKE_PIN_MASK) else $error("input buffers not limited to wake pins");
    buf_run_a: assert property (IO_CLK_EN || CONV_CLK_EN |-> INPUT_BUF_EN == 12'hfff)
        else $error("input buffers off while a clock runs");
    periph_clk_a: assert property (WIDE_TIMER_CLK_EN || NARROW_TIMER_CLK_EN ||
        SERIAL_CLK_EN |-> IO_CLK_EN) else $error("peripheral clock without io clock");
    cmp_ref_a: assert property (!IO_CLK_EN && !CONV_CLK_EN && CMP_POWER_EN |-> REF_EN)
        else $error("comparator on in deep sleep without reference");
    conv_ref_a: assert property (CONV_POWER_EN |-> REF_EN)
        else $error("converter powered without reference");
    gate_resv_a: assert property (PREADY && !PWRITE && PADDR == ADDR_POWER_GATE |->
        PRDATA[31:4] == 28'h0) else $error("gate reserved bits not zero");
endmodule : spg_top_props

bind spg_top spg_top_props #(.STARTUP_CYC(STARTUP_CYC)) spg_top_props_i (
    .MCLK(MCLK), .RESETN(RESETN), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA),
    .PREADY(PREADY), .SLEEP_INSTR(SLEEP_INSTR), .WAKE_IRQ(WAKE_IRQ),
    .WAKE_PIN_MASK(WAKE_PIN_MASK), .CPU_CLK_EN(CPU_CLK_EN), .IO_CLK_EN(IO_CLK_EN),
    .CONV_CLK_EN(CONV_CLK_EN), .WIDE_TIMER_CLK_EN(WIDE_TIMER_CLK_EN),
    .NARROW_TIMER_CLK_EN(NARROW_TIMER_CLK_EN), .SERIAL_CLK_EN(SERIAL_CLK_EN),
    .CONV_POWER_EN(CONV_POWER_EN), .CMP_POWER_EN(CMP_POWER_EN), .REF_EN(REF_EN),
    .INPUT_BUF_EN(INPUT_BUF_EN));

/* File: spg_top_tb.sv */
`timescale 1ns/100ps
// ****************************************
// power control testbench
// ****************************************
module spg_top_tb
    import spg_pkg::*;
;
    localparam logic [15:0] STARTUP = 16'h0002;
    logic mclk, resetn, psel, penable, pwrite, pready, pslverr, sleep_instr, wake_irq;
    logic cpu_en, io_en, conv_en, osc_en, wide_en, narrow_en, serial_en, conv_pwr;
    logic mux_en, cmp_pwr, ref_en, bo_en, wdog, rerr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [11:0] wake_mask, buf_en;
    int error_cnt, num_checks;

    spg_top #(.STARTUP_CYC(STARTUP)) spg_top_i (
        .MCLK(mclk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .SLEEP_INSTR(sleep_instr), .WAKE_IRQ(wake_irq), .WAKE_PIN_MASK(wake_mask),
        .CPU_CLK_EN(cpu_en), .IO_CLK_EN(io_en), .CONV_CLK_EN(conv_en), .OSC_EN(osc_en),
        .WIDE_TIMER_CLK_EN(wide_en), .NARROW_TIMER_CLK_EN(narrow_en),
        .SERIAL_CLK_EN(serial_en), .CONV_POWER_EN(conv_pwr), .CMP_MUX_EN(mux_en),
        .CMP_POWER_EN(cmp_pwr), .REF_EN(ref_en), .BROWNOUT_EN(bo_en),
        .WATCHDOG_RUN(wdog), .INPUT_BUF_EN(buf_en));

    always #5 mclk = ~mclk;

    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("FAIL %s expected %h seen %h", name, exp, got);
            error_cnt++;
        end
    endtask : chk

    // last low keeps psel up for a back-to-back setup
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic last);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        penable <= 1'b0;
        if (last) begin
            psel <= 1'b0;
            @(posedge mclk);
        end
    endtask : apb

    task automatic sleep_pulse();
        sleep_instr <= 1'b1;
        @(posedge mclk);
        sleep_instr <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask : sleep_pulse

    task automatic wake_up();
        int n;
        n = 0;
        wake_irq <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (cpu_en !== 1'b1);
        wake_irq <= 1'b0;
        chk("wake", 32'h1, {31'h0, n >= STARTUP + 4 && n <= STARTUP + 9});
        apb(1'b1, ADDR_POWER_CONTROL, 32'h0, 1'b1);
    endtask : wake_up

    task automatic t_regs();
        apb(1'b0, ADDR_POWER_CONTROL, 32'h0, 1'b1);
        chk("control reset", 32'h0, rdat);
        apb(1'b1, ADDR_POWER_GATE, 32'hff, 1'b1);
        apb(1'b0, ADDR_POWER_GATE, 32'h0, 1'b1);
        chk("gate reserved", 32'h0f, rdat);
        apb(1'b0, 8'h10, 32'h0, 1'b1);
        chk("unmapped", 32'h1, {31'h0, rerr});
    endtask : t_regs

    task automatic t_gate();
        logic [3:0] g;
        apb(1'b1, ADDR_SYS_CONFIG, 32'h08, 1'b1);
        for (int i = 0; i < 5; i++) begin
            g = 4'(32'h1 << i);
            apb(1'b1, ADDR_POWER_GATE, 32'h1 << i, 1'b1);
            if (i == 1) apb(1'b1, ADDR_SYS_CONFIG, 32'h18, 1'b1);
            repeat (2) @(posedge mclk);
            chk("gated", {28'h0, ~g}, {28'h0, wide_en, narrow_en, serial_en, conv_pwr});
            chk("cmp mux", {31'h0, ~g[0]}, {31'h0, mux_en});
            chk("reference", {31'h0, ~g[0]}, {31'h0, ref_en});
        end
    endtask : t_gate

    task automatic t_kinds();
        apb(1'b1, ADDR_SYS_CONFIG, 32'h63, 1'b1);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, ADDR_POWER_CONTROL, 32'h20 | (i << 3), 1'b1);
            sleep_pulse();
            chk("asleep", 32'h0, {31'h0, cpu_en});
            chk("clocks", {29'h0, i == 0, i < 2, i != 2}, {29'h0, io_en, conv_en, osc_en});
            chk("buffers", {20'h0, (i > 1) ? wake_mask : 12'hfff}, {20'h0, buf_en});
            chk("comparator", {31'h0, i < 2}, {31'h0, cmp_pwr});
            chk("wdog detector", 32'h3, {30'h0, wdog, bo_en});
            apb(1'b0, ADDR_STATUS, 32'h0, 1'b1);
            chk("status", 32'h0c | i, rdat);
            wake_up();
        end
        apb(1'b1, ADDR_POWER_CONTROL, 32'h10, 1'b1);
        sleep_pulse();
        chk("no permit", 32'h1, {31'h0, cpu_en});
    endtask : t_kinds

    task automatic bo_try(input logic unlock, input int gap, input int w, input logic off);
        if (unlock) apb(1'b1, ADDR_POWER_CONTROL, 32'hb4, gap != 0);
        repeat (gap) @(posedge mclk);
        apb(1'b1, ADDR_POWER_CONTROL, 32'hb0, 1'b1);
        repeat (w) @(posedge mclk);
        sleep_pulse();
        chk("detector asleep", {31'h0, !off}, {31'h0, bo_en});
        wake_up();
        chk("detector woken", 32'h1, {31'h0, bo_en});
    endtask : bo_try

    task automatic t_brown();
        bo_try(1'b1, 0, 0, 1'b0);
        bo_try(1'b1, 0, 1, 1'b1);
        bo_try(1'b1, 0, 3, 1'b1);
        bo_try(1'b1, 0, 4, 1'b0);
        bo_try(1'b0, 0, 1, 1'b0);
        bo_try(1'b1, 3, 1, 1'b0);
        apb(1'b1, ADDR_POWER_CONTROL, 32'hb4, 1'b0);
        apb(1'b1, ADDR_POWER_CONTROL, 32'hb0, 1'b1);
        repeat (8) @(posedge mclk);
        apb(1'b0, ADDR_POWER_CONTROL, 32'h0, 1'b1);
        chk("off bit cleared", 32'h30, rdat);
    endtask : t_brown

    task automatic t_ref();
        apb(1'b1, ADDR_SYS_CONFIG, 32'h06, 1'b1);
        apb(1'b1, ADDR_POWER_CONTROL, 32'h30, 1'b1);
        sleep_pulse();
        chk("ref in sleep", 32'h3, {30'h0, cmp_pwr, ref_en});
        wake_up();
        apb(1'b1, ADDR_SYS_CONFIG, 32'h0, 1'b1);
        repeat (2) @(posedge mclk);
        chk("ref off", 32'h0, {31'h0, ref_en});
    endtask : t_ref

    initial begin
        mclk = 1'b0;
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        sleep_instr = 1'b0;
        wake_irq = 1'b0;
        wake_mask = 12'h5a3; // analog pins left out of the wake set
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        t_regs();
        t_gate();
        t_kinds();
        t_brown();
        t_ref();
        final_report();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        final_report();
    end
endmodule : spg_top_tb
